// ===== core/dietm_timers.sv
// Dual interval/event timers: 8-bit short counter, 16-bit long counter, toggle output.
// Assumes prescaler taps are one-cycle enables and playback pulse is a level on clk; event pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Short clock source: 00 playback, 01 event pin, 10 div64, 11 div1024.
// - Short counter advances only while short_run; reset clears counter and run bit.
// - Clear-on-match set: short counter clears on each match.
// - Writing short_clear_pulse clears short counter at once, self-clearing.
// - Short compare 00H matches on counter overflow, not on zero.
// - Short compare write is immediate; read returns live count; not reset.
// - Each short match raises short_match_irq.
// - Event mode counts synchronised rising edges of short_event_input.
// - Playback mode counts rising edges of playback_control_pulse.
// - Long clock source: 00 event pin, 01 div4, 10 div16, 11 div64.
// - Long counter advances only while long_run; reset clears counter and run bit.
// - Clear-on-match set: long counter clears on each match.
// - Writing long_clear_pulse clears long counter at once, self-clearing.
// - Low compare byte first; no long compare until high byte written.
// - Long compare 0000H matches on overflow; writes immediate; not reset.
// - Low byte read latches high byte with any carry for the next read.
// - Each long match raises long_match_irq.
// - Long match toggles a flip-flop, halving the match rate.
// - toggle_force_high drives pin to 1, else the flip-flop value.
// - flop_set_pulse sets, flop_clear_pulse clears the flip-flop, one-shot.
// - toggle_output_on enables the pin; write-only, resets to 0.
module dietm_timers
  import dietm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic tap_div4,
  input wire logic tap_div16,
  input wire logic tap_div64,
  input wire logic tap_div1024,
  input wire logic playback_control_pulse,
  input wire logic short_event_input,
  input wire logic long_event_input,
  output logic short_match_irq,
  output logic long_match_irq,
  output logic toggle_output_pin,
  output logic toggle_output_pin_oe
);
  // ****************************************
  // Register port
  // ****************************************
  logic [1:0] run_ctrl;
  logic [7:0] clkclr;
  logic [1:0] toggle_ctrl;
  logic [7:0] short_compare;
  logic [7:0] long_compare_lo;
  logic [7:0] long_compare_hi;
  logic long_armed;
  logic [7:0] short_count;
  logic [15:0] long_count;
  logic [7:0] long_hi_latch;
  logic toggle_flop;
  logic short_run;
  logic long_run;
  logic short_clear_on_match;
  logic long_clear_on_match;
  logic toggle_force_high;
  logic toggle_output_on;
  // Named views of the control bits keep the datapath readable
  assign short_run = run_ctrl[RUN_SHORT_BIT];
  assign long_run = run_ctrl[RUN_LONG_BIT];
  assign short_clear_on_match = clkclr[CC_SHORT_COM_BIT];
  assign long_clear_on_match = clkclr[CC_LONG_COM_BIT];
  assign toggle_force_high = toggle_ctrl[TG_FORCE_BIT];
  assign toggle_output_on = toggle_ctrl[TG_ON_BIT];

  // ****************************************
  // Register decode
  // ****************************************
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target);
    wr_hit = (a == target);
  endfunction

  logic wr_run;
  logic wr_clkclr;
  logic wr_short;
  logic wr_lo;
  logic wr_hi;
  logic wr_tog;
  assign wr_run = reg_write && wr_hit(reg_addr, ADDR_RUN);
  assign wr_clkclr = reg_write && wr_hit(reg_addr, ADDR_CLKCLR);
  assign wr_short = reg_write && wr_hit(reg_addr, ADDR_SHORT);
  assign wr_lo = reg_write && wr_hit(reg_addr, ADDR_LONG_LO);
  assign wr_hi = reg_write && wr_hit(reg_addr, ADDR_LONG_HI);
  assign wr_tog = reg_write && wr_hit(reg_addr, ADDR_TOGGLE);
  logic rd_lo;
  logic rd_hi;
  // A low read freezes the high byte so the pair reads coherently
  assign rd_lo = reg_read && wr_hit(reg_addr, ADDR_LONG_LO);
  assign rd_hi = reg_read && wr_hit(reg_addr, ADDR_LONG_HI);

  // ****************************************
  // Control registers
  // ****************************************

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_ctrl <= RUN_RESET;
      clkclr <= CLKCLR_RESET;
      toggle_ctrl <= TOGGLE_RESET;
    end
    else if (clk_en)
    begin
      if (wr_run)
        run_ctrl <= {reg_wdata[RUN_LONG_BIT], reg_wdata[RUN_SHORT_BIT]};
      if (wr_clkclr)
      begin
        clkclr <= reg_wdata;
        // One-shot clear bits never stay set
        clkclr[CC_SHORT_CLR_BIT] <= 1'b0;
        clkclr[CC_LONG_CLR_BIT] <= 1'b0;
      end
      if (wr_tog)
        toggle_ctrl <= {reg_wdata[TG_ON_BIT], reg_wdata[TG_FORCE_BIT]};
    end
  end

  // ****************************************
  // Compare registers
  // ****************************************
  // Compare registers have no reset on purpose
  // Software must load them before it sets a run bit
  always_ff @(posedge clk)
  begin
    if (clk_en)
    begin
      if (wr_short)
        short_compare <= reg_wdata;
      if (wr_lo)
        long_compare_lo <= reg_wdata;
      if (wr_hi)
        long_compare_hi <= reg_wdata;
    end
  end

  // Long comparator stays off until a high byte arrives after reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      long_armed <= 1'b0;
    else if (clk_en)
    begin
      if (wr_hi)
        long_armed <= 1'b1;
      else if (wr_lo)
        long_armed <= 1'b0;
    end
  end

  // ****************************************
  // Read-back
  // ****************************************
  // Read data one cycle after the strobe; unmapped and write-only read zero
  // Data stand for one cycle only, so a late sample sees zero
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (clk_en)
    begin
      reg_rdata <= 8'h00;
      if (reg_read)
      begin
        case (reg_addr)
          ADDR_RUN: reg_rdata <= {6'h00, run_ctrl};
          ADDR_CLKCLR: reg_rdata <= clkclr;
          ADDR_SHORT: reg_rdata <= short_count;
          ADDR_LONG_LO: reg_rdata <= long_count[7:0];
          ADDR_LONG_HI: reg_rdata <= long_hi_latch;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // Input synchronisers and edge detect
  // ****************************************
  logic [1:0] ev_pin;
  logic [1:0] ev_rise;
  logic pb_prev;
  assign ev_pin = {long_event_input, short_event_input};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ev
      logic [1:0] sync;
      logic prev;
      // Only the second flop feeds the edge test; the first may be metastable
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          sync <= 2'h0;
          prev <= 1'b0;
        end
        else if (clk_en)
        begin
          sync <= {sync[0], ev_pin[gi]};
          prev <= sync[1];
        end
      end
      assign ev_rise[gi] = sync[1] && !prev;
    end
  endgenerate

  // Playback pulse shares clk, so one flop is enough for its edge
  // Its idle level is low, matching the reset value, so no false edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pb_prev <= 1'b0;
    else if (clk_en)
      pb_prev <= playback_control_pulse;
  end

  // ****************************************
  // Clock source select
  // ****************************************
  // Taps are treated as one-cycle enables from the prescaler
  // Event edges count three clocks after the pin rises
  logic short_tick;
  logic long_tick;
  always_comb
  begin
    case (clkclr[CC_SHORT_SEL_LO +: 2])
      2'h0: short_tick = playback_control_pulse && !pb_prev;
      2'h1: short_tick = ev_rise[0];
      2'h2: short_tick = tap_div64;
      default: short_tick = tap_div1024;
    endcase
  end

  always_comb
  begin
    case (clkclr[CC_LONG_SEL_LO +: 2])
      2'h0: long_tick = ev_rise[1];
      2'h1: long_tick = tap_div4;
      2'h2: long_tick = tap_div16;
      default: long_tick = tap_div64;
    endcase
  end

  // ****************************************
  // Short counter
  // ****************************************
  logic short_adv;
  logic short_match;
  assign short_adv = short_run && short_tick;
  // Zero compare means wrap from FF, which the equality below also catches
  assign short_match = short_adv && (short_compare == short_count + 8'h01);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      short_count <= SHORT_COUNT_RESET;
    else if (clk_en)
    begin
      // Clear pulse beats match and tick so software sees zero at once
      if (wr_clkclr && reg_wdata[CC_SHORT_CLR_BIT])
        short_count <= 8'h00;
      else if (short_match && short_clear_on_match)
        short_count <= 8'h00;
      else if (short_adv)
        short_count <= short_count + 8'h01;
    end
  end

  // ****************************************
  // Long counter
  // ****************************************
  logic long_adv;
  logic long_match;
  logic [15:0] long_next;
  assign long_adv = long_run && long_tick;
  assign long_next = long_count + 16'h0001;
  assign long_match = long_adv && long_armed
                      && ({long_compare_hi, long_compare_lo} == long_next);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      long_count <= LONG_COUNT_RESET;
    else if (clk_en)
    begin
      // Same priority as the short counter: clear, then match, then tick
      if (wr_clkclr && reg_wdata[CC_LONG_CLR_BIT])
        long_count <= 16'h0000;
      else if (long_match && long_clear_on_match)
        long_count <= 16'h0000;
      else if (long_adv)
        long_count <= long_next;
    end
  end

  // ****************************************
  // Long count read-back
  // ****************************************
  // High byte follows the counter, frozen from a low read until the high read
  // Limitation: a second low-byte wrap before the high read is added again
  logic hi_frozen;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hi_frozen <= 1'b0;
      long_hi_latch <= 8'h00;
    end
    else if (clk_en)
    begin
      if (rd_lo)
        hi_frozen <= 1'b1;
      else if (rd_hi)
        hi_frozen <= 1'b0;
      // Carry out of the low byte after the low read still lands in the latch
      if (!hi_frozen || (long_adv && long_count[7:0] == 8'hFF
                         && !(long_match && long_clear_on_match)))
        long_hi_latch <= long_adv ? long_next[15:8] : long_count[15:8];
    end
  end

  // ****************************************
  // Match interrupts
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      short_match_irq <= 1'b0;
      long_match_irq <= 1'b0;
    end
    else if (clk_en)
    begin
      short_match_irq <= short_match;
      long_match_irq <= long_match;
    end
  end

  // ****************************************
  // Toggle output
  // ****************************************
  // Flop has no reset value given; cleared so the pin is defined
  // Clear wins over set when both bits are written together
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      toggle_flop <= 1'b0;
    else if (clk_en)
    begin
      if (wr_tog && reg_wdata[TG_CLR_BIT])
        toggle_flop <= 1'b0;
      else if (wr_tog && reg_wdata[TG_SET_BIT])
        toggle_flop <= 1'b1;
      else if (long_match)
        toggle_flop <= !toggle_flop;
    end
  end

  assign toggle_output_pin = toggle_force_high ? 1'b1 : toggle_flop;
  assign toggle_output_pin_oe = toggle_output_on;
endmodule
`default_nettype wire

// ===== core/dietm_pkg.sv
// Package for the dual interval/event timer block.
// Assumes one 40 MHz system clock and a byte-wide register port.
package dietm_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_RUN = 8'h27;
  localparam logic [7:0] ADDR_CLKCLR = 8'h28;
  localparam logic [7:0] ADDR_SHORT = 8'h29;
  localparam logic [7:0] ADDR_LONG_LO = 8'h2A;
  localparam logic [7:0] ADDR_LONG_HI = 8'h2B;
  localparam logic [7:0] ADDR_TOGGLE = 8'h62;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int RUN_SHORT_BIT = 0;
  localparam int RUN_LONG_BIT = 1;
  localparam int CC_SHORT_SEL_LO = 0;
  localparam int CC_SHORT_CLR_BIT = 2;
  localparam int CC_SHORT_COM_BIT = 3;
  localparam int CC_LONG_SEL_LO = 4;
  localparam int CC_LONG_CLR_BIT = 6;
  localparam int CC_LONG_COM_BIT = 7;
  localparam int TG_FORCE_BIT = 0;
  localparam int TG_ON_BIT = 1;
  localparam int TG_SET_BIT = 2;
  localparam int TG_CLR_BIT = 3;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [1:0] RUN_RESET = 2'h0;
  localparam logic [7:0] CLKCLR_RESET = 8'h00;
  localparam logic [1:0] TOGGLE_RESET = 2'h0;
  localparam logic [7:0] SHORT_COUNT_RESET = 8'h00;
  localparam logic [15:0] LONG_COUNT_RESET = 16'h0000;
endpackage

// ===== verif/dietm_chk.sv
// Checker: read-back, counter clears and toggle pin of the dual timers.
// Assumes it is bound to dietm_timers and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dietm_chk
  import dietm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic long_match_irq,
  input wire logic toggle_output_pin,
  input wire logic toggle_output_pin_oe
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic tw;
  logic fq;
  assign tw = reg_write && clk_en && reg_addr == ADDR_TOGGLE;
  // Force bit is write-only, so a private copy is kept here
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      fq <= 1'b0;
    else if (tw)
      fq <= reg_wdata[TG_FORCE_BIT];
  sequence s_wr(a); reg_write && clk_en && reg_addr == a; endsequence
  sequence s_rd(a); reg_read && clk_en && reg_addr == a; endsequence
  property p_idle; $past(clk_en) && !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_run; s_wr(ADDR_RUN) ##2 s_rd(ADDR_RUN)
    |=> reg_rdata == {6'h00, $past(reg_wdata[1:0], 3)}; endproperty
  a_run: assert property (p_run) else $error("run bits lost");
  // One tick may slip in after the clear, hence at most 1
  property p_sclr; s_wr(ADDR_CLKCLR) ##0 reg_wdata[CC_SHORT_CLR_BIT] ##2 s_rd(ADDR_SHORT)
    |=> reg_rdata <= 8'h01; endproperty
  a_sclr: assert property (p_sclr) else $error("short not cleared");
  property p_lclr; s_wr(ADDR_CLKCLR) ##0 reg_wdata[CC_LONG_CLR_BIT] ##2 s_rd(ADDR_LONG_LO)
    |=> reg_rdata <= 8'h01; endproperty
  a_lclr: assert property (p_lclr) else $error("long not cleared");
  property p_wo; s_rd(ADDR_TOGGLE) |=> reg_rdata == 8'h00; endproperty
  a_wo: assert property (p_wo) else $error("toggle reg readable");
  property p_force; s_wr(ADDR_TOGGLE) ##0 reg_wdata[TG_FORCE_BIT] |=> toggle_output_pin; endproperty
  a_force: assert property (p_force) else $error("pin not forced");
  property p_oe; tw |=> toggle_output_pin_oe == $past(reg_wdata[TG_ON_BIT]); endproperty
  a_oe: assert property (p_oe) else $error("enable wrong");
  property p_fset; tw && (reg_wdata[3:0] ==? 4'b01?0) |=> toggle_output_pin; endproperty
  a_fset: assert property (p_fset) else $error("flop not set");
  property p_fclr; tw && (reg_wdata[3:0] ==? 4'b1??0) |=> !toggle_output_pin; endproperty
  a_fclr: assert property (p_fclr) else $error("flop not cleared");
  property p_tog; long_match_irq && !fq && !$past(fq) && !$past(tw)
    |-> toggle_output_pin != $past(toggle_output_pin); endproperty
  a_tog: assert property (p_tog) else $error("flop did not toggle");
endmodule
bind dietm_timers dietm_chk dietm_chk_i (.clk(clk), .resetn(resetn), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .long_match_irq(long_match_irq), .toggle_output_pin(toggle_output_pin),
  .toggle_output_pin_oe(toggle_output_pin_oe));
`default_nettype wire

// ===== verif/dietm_pins.sv
// Far-side pins: clean event pulses in, toggle pin seen through a pull-up.
// Assumes pulse is called right after a rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module dietm_pins
(
  input wire logic clk,
  input wire logic toggle_output_pin,
  input wire logic toggle_output_pin_oe,
  output var logic short_event_input,
  output var logic long_event_input,
  output logic pin_level
);
  // ****************
  // Pins
  // ****************
  // A released pin floats up, so off reads as 1
  assign pin_level = toggle_output_pin_oe ? toggle_output_pin : 1'b1;
  initial
  begin
    short_event_input = 1'b0;
    long_event_input = 1'b0;
  end
  // Four clocks high, four low: the fastest legal event rate
  task automatic pulse(input logic lng);
    {long_event_input, short_event_input} <= lng ? 2'b10 : 2'b01;
    repeat (4) @(posedge clk);
    {long_event_input, short_event_input} <= 2'b00;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Bench: random counts on every clock source, matches, toggle pin.
// Assumes dietm_pkg, dietm_pins and the checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dietm_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] tk = 8'h00;
  logic pb = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] d;
  logic sei, lei, sirq, lirq, pin, oe, level;
  int bad_count = 0, checked = 0, sc = 0, lc = 0, cyc = 0, n, c;
  logic [7:0] ra [7] = '{ADDR_RUN, ADDR_CLKCLR, ADDR_SHORT, ADDR_LONG_LO, ADDR_LONG_HI,
    ADDR_TOGGLE, 8'h30};
  // ****************
  // Harness
  // ****************
  dietm_timers dietm_timers_i (.clk(clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .tap_div4(tk[5]), .tap_div16(tk[6]), .tap_div64(tk[2] | tk[7]), .tap_div1024(tk[3]),
    .playback_control_pulse(pb), .short_event_input(sei), .long_event_input(lei),
    .short_match_irq(sirq), .long_match_irq(lirq), .toggle_output_pin(pin),
    .toggle_output_pin_oe(oe));
  dietm_pins pins_i (.clk(clk), .toggle_output_pin(pin), .toggle_output_pin_oe(oe),
    .short_event_input(sei), .long_event_input(lei), .pin_level(level));
  initial
    forever #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    sc <= sc + int'(sirq === 1'b1);
    lc <= lc + int'(lirq === 1'b1);
    if (cyc == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask
  // Source s: 0 playback, 1 short pin, 2 div64, 3 div1024, 4 long pin, 5 div4, 6 div16, 7 div64
  task automatic tick(input int s, input int k);
    repeat (k)
    begin
      if (s == 1 || s == 4)
        pins_i.pulse(s == 4);
      else if (s == 0)
        pb <= 1'b1;
      else
        tk[s] <= 1'b1;
      @(posedge clk);
      pb <= 1'b0;
      tk <= 8'h00;
      repeat ($urandom_range(2, 1)) @(posedge clk);
    end
  endtask
  function automatic logic [7:0] ccw(input int s, input logic clr);
    return (s >= 4) ? {1'b0, clr, s[1:0], 4'h0} : {4'h0, 1'b0, clr, s[1:0]};
  endfunction
  initial
  begin
    void'($urandom(32'h886F3A6B));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk({8'h00, d}, 16'h0000);
    end
    wr(ADDR_RUN, 8'hFF);
    rd(ADDR_RUN);
    chk({8'h00, d}, 16'h0003);
    wr(ADDR_RUN, 8'h00);
    wr(ADDR_SHORT, 8'hFF);
    wr(ADDR_LONG_LO, 8'hFF);
    wr(ADDR_LONG_HI, 8'hFF);
    for (int s = 0; s < 8; s++)
    begin
      n = $urandom_range(12, 2);
      wr(ADDR_CLKCLR, ccw(s, 1'b0));
      tick(s, n);
      wr(ADDR_RUN, (s >= 4) ? 8'h02 : 8'h01);
      tick(s, n);
      wr(ADDR_RUN, 8'h00);
      rd((s >= 4) ? ADDR_LONG_LO : ADDR_SHORT);
      chk({8'h00, d}, 16'(n));
      wr(ADDR_CLKCLR, ccw(s, 1'b1));
      rd((s >= 4) ? ADDR_LONG_LO : ADDR_SHORT);
      chk({8'h00, d}, 16'h0000);
    end
    c = $urandom_range(30, 2);
    wr(ADDR_CLKCLR, 8'h0E);
    wr(ADDR_SHORT, 8'(c));
    wr(ADDR_RUN, 8'h01);
    n = sc;
    tick(2, c);
    rd(ADDR_SHORT);
    chk({8'h00, d}, 16'h0000);
    wr(ADDR_SHORT, 8'h00);
    tick(2, 255);
    rd(ADDR_SHORT);
    chk(16'(sc - n), 16'h0001);
    tick(2, 1);
    rd(ADDR_SHORT);
    chk(16'(sc - n), 16'h0002);
    wr(ADDR_RUN, 8'h00);
    wr(ADDR_TOGGLE, 8'h0A);
    wr(ADDR_CLKCLR, 8'hD0);
    wr(ADDR_LONG_LO, 8'(c));
    wr(ADDR_LONG_HI, 8'h00);
    wr(ADDR_RUN, 8'h02);
    n = lc;
    for (int k = 1; k <= 2; k++)
    begin
      tick(5, c);
      rd(ADDR_LONG_LO);
      chk({8'h00, d}, 16'h0000);
      chk(16'(lc - n), 16'(k));
      chk({15'h0000, level}, 16'(k % 2));
    end
    // Low byte alone leaves the comparator disarmed
    wr(ADDR_LONG_LO, 8'(c));
    tick(5, c);
    rd(ADDR_LONG_LO);
    chk({8'h00, d}, 16'(c));
    chk(16'(lc - n), 16'h0002);
    wr(ADDR_TOGGLE, 8'h00);
    wr(ADDR_CLKCLR, 8'hD0);
    wr(ADDR_LONG_HI, 8'h00);
    tick(5, c);
    chk({15'h0000, oe}, 16'h0000);
    wr(ADDR_TOGGLE, 8'h02);
    chk({15'h0000, level}, 16'h0001);
    wr(ADDR_TOGGLE, 8'h0B);
    chk({15'h0000, level}, 16'h0001);
    wr(ADDR_TOGGLE, 8'h06);
    chk({15'h0000, level}, 16'h0001);
    wr(ADDR_TOGGLE, 8'h0A);
    chk({15'h0000, level}, 16'h0000);
    // Clock enable low: the set command must not land
    clk_en <= 1'b0;
    wr(ADDR_TOGGLE, 8'h06);
    chk({15'h0000, level}, 16'h0000);
    clk_en <= 1'b1;
    wr(ADDR_CLKCLR, 8'h50);
    wr(ADDR_LONG_LO, 8'hFF);
    wr(ADDR_LONG_HI, 8'hFF);
    tick(5, 255);
    rd(ADDR_LONG_LO);
    chk({8'h00, d}, 16'h00FF);
    tick(5, 1);
    rd(ADDR_LONG_HI);
    chk({8'h00, d}, 16'h0001);
    complete_run();
  end
endmodule
`default_nettype wire
